// >>> vlf_regs.vh
// register subaddresses, field positions, reset values and level constants
// assumes a subaddress write/read port in front of the block
`ifndef VLF_REGS_VH
`define VLF_REGS_VH

`define VLF_SUB_HPF        8'h29
`define VLF_HPF_BIT        0
`define VLF_SUB_LT_FIRST   8'h41
`define VLF_SUB_LT_LAST    8'h57
`define VLF_SUB_VERTICAL_LINE_OFFSET_LO    8'h5a
`define VLF_SUB_VERTICAL_LINE_OFFSET_HI    8'h5b
`define VLF_VOFF8_BIT      4
`define VLF_FIELD_OFFSET_BIT_BIT       7

`define VLF_LT_RESET       8'hff
`define VLF_VERTICAL_LINE_OFFSET_RESET     9'h003
`define VLF_HPF_RESET      1'b0

`define VLF_DT_VBI_COMP    4'h6
`define VLF_DT_ACTIVE      4'hf
`define VLF_ENTRY_FIRST    5'h02
`define VLF_ENTRY_REST     5'h18

`define VLF_CLIP_MIN       8'h01
`define VLF_CLIP_MAX       8'hfe
`define VLF_Y9_MAX         9'h1ff
`define VLF_C9_MID         9'h100
`define VLF_LEVEL_MID      8'h80

`define VLF_KY_R           9'h04d
`define VLF_KY_G           9'h096
`define VLF_KY_B           9'h01d
`define VLF_KCB            9'h094
`define VLF_KCR            9'h0bb

`endif

// >>> vlf_video_level_format.v
// pixel-rate level, matrix, downformatter and line-type logic plus output fifo
// assumes sync stage supplies line_start/field_start pulses on clk, data on clk
`timescale 1ns/1ps
`include "vlf_regs.vh"

module vlf_fifo #(
    parameter W     = 20,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0]  level
);
    reg  [W-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    always @(posedge clk) begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // vlf_fifo

module vlf_video_level_format #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4,
    parameter DEC_ALIGN  = 4
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       reg_wr,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire [7:0] decoder_saturation,
    input  wire [7:0] decoder_contrast,
    input  wire [7:0] decoder_brightness,
    input  wire [7:0] raw_sample_gain,
    input  wire [7:0] raw_sample_offset,
    input  wire [7:0] component_saturation,
    input  wire [7:0] component_contrast,
    input  wire [7:0] component_brightness,
    input  wire       pix_valid,
    output reg        pix_ready,
    input  wire [7:0] dec_y,
    input  wire [7:0] dec_cb,
    input  wire [7:0] dec_cr,
    input  wire [7:0] dec_raw,
    input  wire [8:0] comp_r_y,
    input  wire [8:0] comp_g_cb,
    input  wire [8:0] comp_b_cr,
    input  wire       comp_is_ycbcr,
    input  wire       comp_select,
    input  wire       line_start,
    input  wire       field_start,
    input  wire       field_odd,
    output wire       out_valid,
    input  wire       out_ready,
    output wire [7:0] out_y,
    output wire [7:0] out_c,
    output wire       out_phase,
    output wire       out_raw,
    output wire       out_vbi,
    output reg        raw_line_flag,
    output reg        vbi_line_flag,
    output reg        luma_comb_enable,
    output reg        delay_line_filter_off
);
    localparam NUM_LT = 23;
    localparam FW     = 20;

    // level helpers
    function [7:0] clip8;
        input signed [19:0] v;
        begin
            if (v < $signed({12'h000, `VLF_CLIP_MIN}))
                clip8 = `VLF_CLIP_MIN;
            else if (v > $signed({12'h000, `VLF_CLIP_MAX}))
                clip8 = `VLF_CLIP_MAX;
            else
                clip8 = v[7:0];
        end
    endfunction

    function [7:0] gain_off;
        input [7:0] x;
        input [7:0] g;
        input [7:0] off;
        reg [15:0] m;
        reg signed [19:0] p;
        begin
            m = x * g;
            p = $signed({4'h0, m}) >>> 7;
            gain_off = clip8(p + $signed({12'h000, off}) - $signed({12'h000, `VLF_LEVEL_MID}));
        end
    endfunction

    function [7:0] sat_adj;
        input [7:0] x;
        input [7:0] s;
        reg signed [19:0] d;
        reg signed [19:0] p;
        begin
            d = $signed({12'h000, x}) - $signed({12'h000, `VLF_LEVEL_MID});
            p = (d * $signed({12'h000, s})) >>> 7;
            sat_adj = clip8(p + $signed({12'h000, `VLF_LEVEL_MID}));
        end
    endfunction

    // registers
    reg  [7:0] lt_q [0:NUM_LT-1];
    reg  [8:0] vertical_line_offset_q;
    reg        field_offset_bit_q;
    reg        hpf_en_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LT; gi = gi + 1) begin : g_lt
            always @(posedge clk) begin
                if (!rst_n)
                    lt_q[gi] <= `VLF_LT_RESET;
                else if (reg_wr && reg_addr == `VLF_SUB_LT_FIRST + gi)
                    lt_q[gi] <= reg_wdata;
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_n) begin
            vertical_line_offset_q   <= `VLF_VERTICAL_LINE_OFFSET_RESET;
            field_offset_bit_q   <= 1'b0;
            hpf_en_q <= `VLF_HPF_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `VLF_SUB_HPF)
                hpf_en_q <= reg_wdata[`VLF_HPF_BIT];
            if (reg_addr == `VLF_SUB_VERTICAL_LINE_OFFSET_LO)
                vertical_line_offset_q[7:0] <= reg_wdata;
            if (reg_addr == `VLF_SUB_VERTICAL_LINE_OFFSET_HI) begin
                vertical_line_offset_q[8] <= reg_wdata[`VLF_VOFF8_BIT];
                field_offset_bit_q    <= reg_wdata[`VLF_FIELD_OFFSET_BIT_BIT];
            end
        end
    end

    wire [7:0] lt_idx = reg_addr - `VLF_SUB_LT_FIRST;
    always @(posedge clk) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_addr >= `VLF_SUB_LT_FIRST && reg_addr <= `VLF_SUB_LT_LAST)
            reg_rdata <= lt_q[lt_idx[4:0]];
        else if (reg_addr == `VLF_SUB_HPF)
            reg_rdata <= {7'h00, hpf_en_q};
        else if (reg_addr == `VLF_SUB_VERTICAL_LINE_OFFSET_LO)
            reg_rdata <= vertical_line_offset_q[7:0];
        else if (reg_addr == `VLF_SUB_VERTICAL_LINE_OFFSET_HI)
            reg_rdata <= {field_offset_bit_q, 2'b00, vertical_line_offset_q[8], 4'h0};
        else
            reg_rdata <= 8'h00;
    end

    // line counting and data type selection
    reg  [9:0] line_q;
    wire [9:0] field_shift = {9'h000, field_offset_bit_q & ~field_odd};
    wire [9:0] eff_line = line_q - {1'b0, vertical_line_offset_q} - field_shift;
    reg  [4:0] entry;
    always @* begin
        if (eff_line >= {5'h00, `VLF_ENTRY_FIRST} && eff_line < {5'h00, `VLF_ENTRY_REST})
            entry = eff_line[4:0];
        else
            entry = `VLF_ENTRY_REST;
    end
    wire [7:0] entry_val = lt_q[entry - `VLF_ENTRY_FIRST];
    wire [3:0] dtype = field_odd ? entry_val[7:4] : entry_val[3:0];
    wire       is_comp = (dtype == `VLF_DT_VBI_COMP) || (dtype == `VLF_DT_ACTIVE);

    always @(posedge clk) begin
        if (!rst_n) begin
            line_q                <= 10'h000;
            raw_line_flag         <= 1'b0;
            vbi_line_flag         <= 1'b0;
            luma_comb_enable      <= 1'b1;
            delay_line_filter_off <= 1'b0;
        end else begin
            if (field_start)
                line_q <= 10'h001;
            else if (line_start)
                line_q <= line_q + 1'b1;
            if (line_start) begin
                raw_line_flag         <= ~is_comp;
                vbi_line_flag         <= (dtype != `VLF_DT_ACTIVE);
                luma_comb_enable      <= (dtype == `VLF_DT_ACTIVE);
                delay_line_filter_off <= (dtype != `VLF_DT_ACTIVE);
            end
        end
    end

    // decoder level stage
    reg [7:0] dy_q;
    reg [7:0] dcb_q;
    reg [7:0] dcr_q;
    reg [7:0] draw_q;
    always @(posedge clk) begin
        dy_q   <= gain_off(dec_y, decoder_contrast, decoder_brightness);
        dcb_q  <= sat_adj(dec_cb, decoder_saturation);
        dcr_q  <= sat_adj(dec_cr, decoder_saturation);
        draw_q <= gain_off(dec_raw, raw_sample_gain, raw_sample_offset);
    end

    reg [31:0] dec_dl_q [0:DEC_ALIGN-1];
    integer k;
    always @(posedge clk) begin
        dec_dl_q[0] <= {dy_q, dcb_q, dcr_q, draw_q};
        for (k = 1; k < DEC_ALIGN; k = k + 1)
            dec_dl_q[k] <= dec_dl_q[k-1];
    end
    wire [31:0] dec_al = dec_dl_q[DEC_ALIGN-1];

    // rgb to ycbcr matrix, two stages, bypass matched
    reg  [8:0]  m1_y_q;
    reg  [8:0]  m1_r_q;
    reg  [8:0]  m1_b_q;
    reg  [26:0] m1_byp_q;
    reg         m1_sel_q;
    wire [19:0] ysum = comp_r_y * `VLF_KY_R + comp_g_cb * `VLF_KY_G + comp_b_cr * `VLF_KY_B;
    always @(posedge clk) begin
        m1_y_q   <= ysum[16:8];
        m1_r_q   <= comp_r_y;
        m1_b_q   <= comp_b_cr;
        m1_byp_q <= {comp_r_y, comp_g_cb, comp_b_cr};
        m1_sel_q <= comp_is_ycbcr;
    end

    wire signed [19:0] bdiff = $signed({11'h000, m1_b_q}) - $signed({11'h000, m1_y_q});
    wire signed [19:0] rdiff = $signed({11'h000, m1_r_q}) - $signed({11'h000, m1_y_q});
    wire signed [19:0] cbm   = ((bdiff * $signed({11'h000, `VLF_KCB})) >>> 8)
                               + $signed({11'h000, `VLF_C9_MID});
    wire signed [19:0] crm   = ((rdiff * $signed({11'h000, `VLF_KCR})) >>> 8)
                               + $signed({11'h000, `VLF_C9_MID});
    reg [8:0] m2_y_q;
    reg [8:0] m2_cb_q;
    reg [8:0] m2_cr_q;
    always @(posedge clk) begin
        if (m1_sel_q) begin
            m2_y_q  <= m1_byp_q[26:18];
            m2_cb_q <= m1_byp_q[17:9];
            m2_cr_q <= m1_byp_q[8:0];
        end else begin
            m2_y_q  <= m1_y_q;
            m2_cb_q <= cbm[8:0];
            m2_cr_q <= crm[8:0];
        end
    end

    // downformatter: chroma low-pass, luma delay taps and high-pass
    reg  [8:0] cb_t1_q;
    reg  [8:0] cb_t2_q;
    reg  [8:0] cr_t1_q;
    reg  [8:0] cr_t2_q;
    reg  [8:0] y_t1_q;
    reg  [8:0] y_t2_q;
    wire [10:0] cb_sum = {2'b00, m2_cb_q} + {1'b0, cb_t1_q, 1'b0} + {2'b00, cb_t2_q};
    wire [10:0] cr_sum = {2'b00, m2_cr_q} + {1'b0, cr_t1_q, 1'b0} + {2'b00, cr_t2_q};
    wire signed [12:0] hp_edge = $signed({3'b000, y_t1_q, 1'b0})
                                 - $signed({4'h0, m2_y_q}) - $signed({4'h0, y_t2_q});
    wire signed [12:0] hp_raw  = $signed({4'h0, y_t1_q}) + (hp_edge >>> 4);
    reg  [8:0] cb_f_q;
    reg  [8:0] cr_f_q;
    reg  [8:0] cr_d_q;
    reg  [8:0] y_f_q;
    always @(posedge clk) begin
        cb_t1_q <= m2_cb_q;
        cb_t2_q <= cb_t1_q;
        cr_t1_q <= m2_cr_q;
        cr_t2_q <= cr_t1_q;
        y_t1_q  <= m2_y_q;
        y_t2_q  <= y_t1_q;
        cb_f_q  <= cb_sum[10:2];
        cr_f_q  <= cr_sum[10:2];
        cr_d_q  <= cr_f_q;
        if (!hpf_en_q)
            y_f_q <= y_t1_q;
        else if (hp_raw < 0)
            y_f_q <= 9'h000;
        else if (hp_raw > $signed({4'h0, `VLF_Y9_MAX}))
            y_f_q <= `VLF_Y9_MAX;
        else
            y_f_q <= hp_raw[8:0];
    end

    // multiplex phase: 0 = first clock of slot, blue difference
    reg       phase_q;
    reg [8:0] cmux_q;
    reg [8:0] y_m_q;
    reg       phase_m_q;
    always @(posedge clk) begin
        if (!rst_n || line_start)
            phase_q <= 1'b0;
        else
            phase_q <= ~phase_q;
        cmux_q    <= phase_q ? cr_d_q : cb_f_q;
        y_m_q     <= y_f_q;
        phase_m_q <= phase_q;
    end

    // component level stage
    reg [7:0] cy_q;
    reg [7:0] cc_q;
    reg       cphase_q;
    always @(posedge clk) begin
        cy_q     <= gain_off(y_m_q[8:1], component_contrast, component_brightness);
        cc_q     <= sat_adj(cmux_q[8:1], component_saturation);
        cphase_q <= phase_m_q;
    end

    // valid pipeline matching the component latency
    reg [6:0] vld_q;
    always @(posedge clk) begin
        if (!rst_n)
            vld_q <= 7'h00;
        else
            vld_q <= {vld_q[5:0], pix_valid & pix_ready};
    end

    // output selection into fifo
    wire [7:0] dsel_c = cphase_q ? dec_al[15:8] : dec_al[23:16];
    wire [7:0] sel_y  = raw_line_flag ? dec_al[7:0] : (comp_select ? cy_q : dec_al[31:24]);
    wire [7:0] sel_c  = raw_line_flag ? `VLF_LEVEL_MID : (comp_select ? cc_q : dsel_c);
    wire [FW-1:0] fin = {sel_y, sel_c, cphase_q, raw_line_flag, vbi_line_flag, 1'b0};
    wire [FW-1:0] fout;
    wire          fin_ready;
    wire [FIFO_AW:0] flevel;

    vlf_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (vld_q[6]),
        .in_ready  (fin_ready),
        .in_data   (fin),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fout),
        .level     (flevel)
    );

    // stall the source early enough to absorb the pipeline in flight
    always @(posedge clk) begin
        if (!rst_n)
            pix_ready <= 1'b0;
        else
            pix_ready <= fin_ready && ({{(31-FIFO_AW){1'b0}}, flevel} + 32'd9 <= FIFO_DEPTH);
    end

    assign out_y     = fout[19:12];
    assign out_c     = fout[11:4];
    assign out_phase = fout[3];
    assign out_raw   = fout[2];
    assign out_vbi   = fout[1];
endmodule // vlf_video_level_format

// >>> vlf_level_format_sva.sv
// concurrent checks on the ports of the level, matrix and line-type block
// assumes a single pixel clock and synchronous active-low reset
`timescale 1ns/1ps
module vlf_level_format_sva (
    input logic       clk,
    input logic       rst_n,
    input logic       reg_wr,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic       line_start,
    input logic       out_valid,
    input logic       out_ready,
    input logic [7:0] out_y,
    input logic [7:0] out_c,
    input logic       out_phase,
    input logic       out_raw,
    input logic       out_vbi,
    input logic       raw_line_flag,
    input logic       vbi_line_flag,
    input logic       luma_comb_enable,
    input logic       delay_line_filter_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_clip_range: assert property (out_valid |-> out_y inside {[8'h01:8'hfe]}
        && out_c inside {[8'h01:8'hfe]}) else $error("output code outside 1..254");
    chk_flags_hold: assert property (!line_start |=> $stable({raw_line_flag,
        vbi_line_flag, luma_comb_enable, delay_line_filter_off}))
        else $error("line flags moved without line start");
    chk_rdata_write: assert property (reg_wr && reg_addr inside {[8'h41:8'h57], 8'h5a}
        ##1 (!reg_wr && $stable(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read data does not show written value");
    chk_unmapped_zero: assert property (reg_addr inside {8'h58, 8'h59, [8'h5c:8'hff]}
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_word_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable({out_y, out_c, out_phase, out_raw, out_vbi}))
        else $error("output word changed while stalled");
    chk_raw_word: assert property (out_valid && out_raw |-> out_c == 8'h80 && out_vbi)
        else $error("raw word chroma or vbi wrong");
    chk_raw_vbi: assert property (raw_line_flag |-> vbi_line_flag)
        else $error("raw line without vbi flag");
    chk_comb_bypass: assert property (luma_comb_enable == !vbi_line_flag)
        else $error("comb enable disagrees with line type");
    chk_dlf_off: assert property (delay_line_filter_off == vbi_line_flag)
        else $error("delay line filter disagrees with line type");
endmodule // vlf_level_format_sva

bind vlf_video_level_format vlf_level_format_sva u_sva (.*);

// >>> vlf_sink_model.sv
// scaler and slicer side: drains the output fifo and records every word
// assumes stall is driven by the bench just after a rising edge
`timescale 1ns/1ps
module vlf_sink_model (
    input  logic       clk,
    input  logic       rst_n,
    input  logic       stall,
    input  logic       out_valid,
    output logic       out_ready,
    input  logic [7:0] out_y,
    input  logic [7:0] out_c,
    input  logic       out_phase,
    input  logic       out_raw,
    input  logic       out_vbi
);
    logic [18:0] words[$];

    assign out_ready = rst_n & ~stall;
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            words.push_back({out_raw, out_vbi, out_phase, out_y, out_c});
        end
    end
endmodule // vlf_sink_model

// >>> vlf_video_level_format_tb.sv
// self-checking bench for the level, matrix, downformatter and line-type block
// assumes the sink model drains the fifo and keeps every word it takes
`timescale 1ns/1ps
module vlf_video_level_format_tb;
    logic        clk, rst_n, reg_wr, pix_valid, pix_ready, comp_is_ycbcr, comp_select;
    logic        line_start, field_start, field_odd, stall, out_valid, out_ready;
    logic        out_phase, out_raw, out_vbi, raw_line_flag, vbi_line_flag;
    logic        luma_comb_enable, delay_line_filter_off, field_offset_bit;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, dec_y, dec_cb, dec_cr, dec_raw, out_y, out_c;
    logic [7:0]  decoder_saturation, decoder_contrast, decoder_brightness;
    logic [7:0]  raw_sample_gain, raw_sample_offset;
    logic [7:0]  component_saturation, component_contrast, component_brightness;
    logic [8:0]  comp_r_y, comp_g_cb, comp_b_cr, vertical_line_offset;
    logic [7:0]  ent[2:24];
    int          err_total, compares, cyc, taken;

    vlf_video_level_format dut (.*);
    vlf_sink_model sink (.*);

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (pix_valid && pix_ready) taken++;
        if (cyc == 8000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_addr = a;
        tick();
        chk(32'(reg_rdata), 32'(exp), what);
    endtask

    // one strobe cycle then one quiet cycle, so strobes never merge
    task automatic strobe(input logic fs);
        field_start = fs;
        line_start = !fs;
        tick();
        field_start = 0;
        line_start = 0;
        tick();
    endtask

    task automatic chk_line(input int l);
        logic [7:0] e;
        logic [3:0] t;
        int         k;
        k = l - int'(vertical_line_offset) - int'(field_offset_bit & !field_odd);
        e = (k >= 2 && k <= 23) ? ent[k] : ent[24];
        t = field_odd ? e[7:4] : e[3:0];
        chk(32'({raw_line_flag, vbi_line_flag, luma_comb_enable, delay_line_filter_off}),
            32'({t != 4'h6 && t != 4'hf, t != 4'hf, t == 4'hf, t != 4'hf}), "line flags");
    endtask

    // whole field takes entry 24; checks the last two words of a constant stream
    task automatic stream(input logic [7:0] lt, input logic st, input logic [7:0] ey,
                          input logic [7:0] ecb, input logic [7:0] ecr, input string what);
        logic [18:0] w;
        logic        last_ph;
        wr(8'h57, lt);
        strobe(1);
        strobe(0);
        sink.words.delete();
        taken = 0;
        stall = st;
        pix_valid = 1;
        repeat (24) tick();
        if (st) chk(32'(pix_ready), 32'h0, "pix_ready under stall");
        pix_valid = 0;
        stall = 0;
        repeat (40) tick();
        chk(32'(sink.words.size()), 32'(taken), "word count");
        last_ph = sink.words[sink.words.size() - 1][16];
        for (int i = 1; i <= 2; i++) begin
            w = sink.words[sink.words.size() - i];
            chk(32'(w), 32'({lt[7:4] != 4'h6 && lt[7:4] != 4'hf, lt[7:4] != 4'hf, w[16], ey,
                w[16] ? ecr : ecb}), what);
        end
        chk(32'(w[16] ^ last_ph), 32'h1, "phase toggle");
    endtask

    initial begin
        {reg_wr, pix_valid, comp_is_ycbcr, comp_select, line_start, field_start, stall} = '0;
        {reg_addr, reg_wdata, dec_y, dec_cb, dec_cr, dec_raw} = '0;
        {decoder_saturation, decoder_contrast, decoder_brightness} = {3{8'h80}};
        {raw_sample_gain, raw_sample_offset} = {2{8'h80}};
        {component_saturation, component_contrast, component_brightness} = {3{8'h80}};
        {comp_r_y, comp_g_cb, comp_b_cr} = '0;
        field_odd = 1;
        rst_n = 0;
        repeat (16) tick();
        rst_n = 1;
        repeat (2) tick();
        rd(8'h41, 8'hff, "entry 2 reset");
        rd(8'h57, 8'hff, "entry 24 reset");
        rd(8'h5a, 8'h03, "offset reset");
        rd(8'h5b, 8'h00, "offset high reset");
        rd(8'h29, 8'h00, "highpass reset");
        rd(8'h58, 8'h00, "unmapped read");
        for (int e = 2; e <= 24; e++) begin
            ent[e] = {4'(e - 2), 4'(e + 7)};
            wr(8'(8'h3f + e), ent[e]);
            rd(8'(8'h3f + e), ent[e], "line entry");
        end
        for (int p = 0; p < 3; p++) begin
            vertical_line_offset = (p == 0) ? 9'h003 : (p == 1) ? 9'h006 : 9'h101;
            field_offset_bit = (p == 1);
            field_odd = (p != 1);
            wr(8'h5a, vertical_line_offset[7:0]);
            wr(8'h5b, {field_offset_bit, 2'b00, vertical_line_offset[8], 4'h0});
            rd(8'h5b, {field_offset_bit, 2'b00, vertical_line_offset[8], 4'h0}, "offset high");
            strobe(1);
            for (int l = 1; l <= 26; l++) begin
                strobe(0);
                chk_line(l);
            end
        end
        field_odd = 1;
        dec_y = 8'd100;
        dec_cb = 8'd60;
        dec_cr = 8'd200;
        stream(8'hff, 0, 8'd100, 8'd60, 8'd200, "decoder nominal");
        dec_y = 8'h00;
        dec_cb = 8'h00;
        dec_cr = 8'hff;
        stream(8'hff, 0, 8'h01, 8'h01, 8'hfe, "decoder clip");
        dec_y = 8'd200;
        decoder_contrast = 8'h40;
        decoder_brightness = 8'h90;
        decoder_saturation = 8'h00;
        stream(8'h66, 0, 8'd116, 8'h80, 8'h80, "decoder levels");
        dec_raw = 8'd100;
        raw_sample_gain = 8'h40;
        raw_sample_offset = 8'h90;
        stream(8'h00, 1, 8'd66, 8'h80, 8'h80, "raw line");
        comp_select = 1;
        comp_is_ycbcr = 1;
        comp_r_y = 9'd200;
        comp_g_cb = 9'h0c0;
        comp_b_cr = 9'h140;
        stream(8'hff, 0, 8'd100, 8'h60, 8'ha0, "component bypass");
        comp_is_ycbcr = 0;
        component_contrast = 8'h40;
        {comp_r_y, comp_g_cb, comp_b_cr} = {3{9'd400}};
        wr(8'h29, 8'h01);
        stream(8'hff, 0, 8'd100, 8'h80, 8'h80, "matrix grey");
        component_contrast = 8'h80;
        component_saturation = 8'h00;
        {comp_r_y, comp_g_cb, comp_b_cr} = {3{9'h1ff}};
        stream(8'hff, 0, 8'hfe, 8'h80, 8'h80, "matrix clip");
        finish_test();
    end
endmodule // vlf_video_level_format_tb
